/* hdl/ecph_pkg.sv */
// shared constants and types for the ecp host-side handshake block
package ecph_pkg;

  // ==========================================================================
  // widths and sizes
  localparam int unsigned ECPH_DATA_W    = 8;   // parallel data lines
  localparam int unsigned ECPH_WORD_W    = 9;   // data plus command flag
  localparam int unsigned ECPH_BUF_DEPTH = 2;   // reverse path buffer entries
  localparam int unsigned ECPH_SYNC_W    = 13;  // 8 data + 5 status inputs

  // ==========================================================================
  // field positions inside a buffered reverse word
  localparam int unsigned ECPH_CMD_BIT   = 8;   // command flag position

  // ==========================================================================
  // field positions inside the synchronised input vector
  localparam int unsigned ECPH_IN_BUSY   = 8;   // peripheral ack / busy
  localparam int unsigned ECPH_IN_ACK    = 9;   // byte ack, active low
  localparam int unsigned ECPH_IN_ACKREV = 10;  // direction ack, active low
  localparam int unsigned ECPH_IN_PREQ   = 11;  // peripheral request, low
  localparam int unsigned ECPH_IN_SEL    = 12;  // printer on line

  // ==========================================================================
  // reset values
  localparam logic [ECPH_DATA_W-1:0] ECPH_DATA_RST = 8'h00;
  // acks and request idle high, so no false request follows reset
  localparam logic [ECPH_SYNC_W-1:0] ECPH_SYNC_RST = 13'h0E00;
  localparam logic                   ECPH_PIN_IDLE = 1'b1;     // strobes high

  // ==========================================================================
  // handshake states
  typedef enum logic [2:0]
  {
    ECPH_FWD_IDLE = 3'b000,  // forward, waiting for a byte to send
    ECPH_FWD_STRB = 3'b001,  // strobe low, waiting for busy high
    ECPH_FWD_REL  = 3'b010,  // strobe high, waiting for busy low
    ECPH_TO_REV   = 3'b011,  // direction low, waiting for reverse ack
    ECPH_REV_IDLE = 3'b100,  // reverse, waiting for byte ack low
    ECPH_REV_TAKE = 3'b101,  // host ack high, waiting for byte ack high
    ECPH_TO_FWD   = 3'b110   // direction high, waiting for reverse ack off
  } ecph_state_t;

endpackage : ecph_pkg

/* hdl/ecph_stream_if.sv */
// valid/ready word stream between the port logic and its buffer
`timescale 1ns/1ps
`default_nettype none

interface ecph_stream_if #(parameter int unsigned W = 9);
  logic         valid;  // word offered
  logic         ready;  // word accepted
  logic [W-1:0] data;   // word payload

  // producer side
  modport src (output valid, output data, input ready);
  // consumer side
  modport snk (input valid, input data, output ready);
endinterface : ecph_stream_if

`default_nettype wire

/* hdl/ecph_rev_buf.sv */
// two-entry valid/ready buffer on the reverse data path
`timescale 1ns/1ps
`default_nettype none

module ecph_rev_buf
  import ecph_pkg::*;
#(
  parameter int unsigned W     = ECPH_WORD_W,
  parameter int unsigned DEPTH = ECPH_BUF_DEPTH
)
(
  input  wire logic clk,
  input  wire logic rst,
  ecph_stream_if.snk in_s,
  ecph_stream_if.src out_s
);

  // ==========================================================================
  // storage and pointers
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];   // entry array
  logic [PW-1:0] wr_ptr_ff;        // next slot to fill
  logic [PW-1:0] rd_ptr_ff;        // oldest slot
  logic [CW-1:0] cnt_ff;           // entries held
  logic [PW-1:0] nxt_wr_ptr;
  logic [PW-1:0] nxt_rd_ptr;
  logic [CW-1:0] nxt_cnt;
  logic          push;             // accepted write
  logic          pop;              // accepted read

  // honest full and empty flags drive the handshakes
  assign in_s.ready  = (cnt_ff != CW'(DEPTH));
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data  = mem_ff[rd_ptr_ff];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  // pointer wrap, works for depths that are not a power of two
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // next pointer and count values
  always_comb
  begin
    nxt_wr_ptr = push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
    nxt_rd_ptr = pop ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
    nxt_cnt    = cnt_ff + CW'(push) - CW'(pop);
  end

  // register pointers; data array needs no reset, gated by count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff    <= nxt_cnt;
    end
  end

  // write port of the entry array
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_s.data;
    end
  end

endmodule // ecph_rev_buf

`default_nettype wire

/* hdl/ecph_port.sv */
// host-side ecp parallel port handshake engine
`timescale 1ns/1ps
`default_nettype none

module ecph_port
  import ecph_pkg::*;
#(
  parameter int unsigned DW = ECPH_DATA_W
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  // control from the port logic
  input  wire logic          ecp_en,        // ecp mode active
  input  wire logic          want_rev,      // host chooses reverse
  output logic               dir_rev,       // channel is reverse
  output logic               err_irq,       // peripheral request seen
  output logic               online,        // printer on line
  // forward byte stream
  input  wire logic          fwd_valid,
  output logic               fwd_ready,
  input  wire logic [DW-1:0] fwd_data,
  input  wire logic          fwd_cmd,       // byte is address/command
  // reverse byte stream
  output logic               rev_valid,
  input  wire logic          rev_ready,
  output logic [DW-1:0]      rev_data,
  output logic               rev_cmd,       // byte is command info
  // parallel pins
  output logic               strobe_n,
  output logic               host_ack,
  output logic               dir_n,         // low selects reverse
  output logic               select_in_n,
  output logic [DW-1:0]      pdata_o,
  output logic               pdata_oe,
  input  wire logic [DW-1:0] pdata_i,
  input  wire logic          periph_ack,    // busy line
  input  wire logic          ack_n,
  input  wire logic          ack_rev_n,
  input  wire logic          periph_req_n,
  input  wire logic          select
);

  // ==========================================================================
  // input synchronisers
  // every pin crosses two flops; stage one feeds only stage two
  logic [ECPH_SYNC_W-1:0] sync1_ff;   // first stage, metastable
  logic [ECPH_SYNC_W-1:0] sync2_ff;   // second stage, safe to use
  logic [ECPH_SYNC_W-1:0] pins_raw;

  assign pins_raw = {select, periph_req_n, ack_rev_n, ack_n, periph_ack,
                     pdata_i};

  // two-flop chain for all inputs at once
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_ff <= ECPH_SYNC_RST;
      sync2_ff <= ECPH_SYNC_RST;
    end
    else
    begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic          s_busy;     // synced busy / peripheral ack
  logic          s_ack_n;    // synced byte ack
  logic          s_arev_n;   // synced reverse ack
  logic          s_preq_n;   // synced peripheral request
  logic          s_sel;      // synced select
  logic [DW-1:0] s_data;     // synced data lines

  assign s_busy   = sync2_ff[ECPH_IN_BUSY];
  assign s_ack_n  = sync2_ff[ECPH_IN_ACK];
  assign s_arev_n = sync2_ff[ECPH_IN_ACKREV];
  assign s_preq_n = sync2_ff[ECPH_IN_PREQ];
  assign s_sel    = sync2_ff[ECPH_IN_SEL];
  assign s_data   = sync2_ff[DW-1:0];

  // ==========================================================================
  // reverse buffer
  // a stalled consumer holds host ack low, so the peripheral waits
  ecph_stream_if #(.W(ECPH_WORD_W)) cap_s ();
  ecph_stream_if #(.W(ECPH_WORD_W)) drn_s ();

  ecph_rev_buf #(
    .W     (ECPH_WORD_W),
    .DEPTH (ECPH_BUF_DEPTH)
  ) u_rev_buf (
    .clk   (clk),
    .rst   (rst),
    .in_s  (cap_s),
    .out_s (drn_s)
  );

  assign rev_valid     = drn_s.valid;
  assign drn_s.ready   = rev_ready;
  assign rev_data      = drn_s.data[DW-1:0];
  assign rev_cmd       = drn_s.data[ECPH_CMD_BIT];

  // ==========================================================================
  // handshake state machine
  ecph_state_t   state_ff;     // current step
  ecph_state_t   nxt_state;
  logic [DW-1:0] pdata_ff;     // forward byte on the lines
  logic [DW-1:0] nxt_pdata;
  logic          strobe_n_ff;  // forward strobe
  logic          nxt_strobe_n;
  logic          hack_ff;      // host ack pin level
  logic          nxt_hack;
  logic          dir_n_ff;     // direction pin level
  logic          nxt_dir_n;
  logic          oe_ff;        // data line drive enable
  logic          nxt_oe;
  logic          cap_push;     // reverse byte captured

  // forward take: idle, peripheral not busy, channel forward
  assign fwd_ready = (state_ff == ECPH_FWD_IDLE) & ecp_en & ~want_rev &
                     ~s_busy & s_arev_n;

  // capture when the peripheral offers a byte and there is room
  assign cap_push   = (state_ff == ECPH_REV_IDLE) & ~s_ack_n & cap_s.ready;
  assign cap_s.valid = cap_push;
  // busy low in reverse marks command information
  assign cap_s.data  = {~s_busy, s_data};

  // next-step logic
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_pdata    = pdata_ff;
    nxt_strobe_n = strobe_n_ff;
    nxt_hack     = hack_ff;
    nxt_dir_n    = dir_n_ff;
    nxt_oe       = oe_ff;
    case (state_ff)
      ECPH_FWD_IDLE:
      begin
        nxt_strobe_n = ECPH_PIN_IDLE;
        nxt_dir_n    = 1'b1;
        // drive only while reverse ack says forward
        nxt_oe       = ecp_en & s_arev_n;
        // peripheral request never turns the bus by itself
        if (ecp_en && want_rev)
        begin
          nxt_oe    = 1'b0;     // release lines before turning
          nxt_hack  = 1'b0;
          nxt_dir_n = 1'b0;
          nxt_state = ECPH_TO_REV;
        end
        else if (fwd_valid && fwd_ready)
        begin
          nxt_pdata    = fwd_data;
          // host ack low flags an address/command byte
          nxt_hack     = ~fwd_cmd;
          nxt_strobe_n = 1'b0;
          nxt_state    = ECPH_FWD_STRB;
        end
      end
      ECPH_FWD_STRB:
      begin
        // hold strobe until the peripheral shows busy
        if (s_busy)
        begin
          nxt_strobe_n = ECPH_PIN_IDLE;
          nxt_state    = ECPH_FWD_REL;
        end
      end
      ECPH_FWD_REL:
      begin
        // next byte only after busy falls again
        if (!s_busy)
        begin
          nxt_state = ECPH_FWD_IDLE;
        end
      end
      ECPH_TO_REV:
      begin
        // wait for the peripheral to acknowledge reverse
        if (!s_arev_n)
        begin
          nxt_state = ECPH_REV_IDLE;
        end
      end
      ECPH_REV_IDLE:
      begin
        nxt_oe = 1'b0;
        if (cap_push)
        begin
          // raise host ack once the byte is held
          nxt_hack  = 1'b1;
          nxt_state = ECPH_REV_TAKE;
        end
        else if (!want_rev || !ecp_en)
        begin
          nxt_dir_n = 1'b1;
          nxt_state = ECPH_TO_FWD;
        end
      end
      ECPH_REV_TAKE:
      begin
        // drop host ack only after ack rises: interlock
        if (s_ack_n)
        begin
          nxt_hack  = 1'b0;
          nxt_state = ECPH_REV_IDLE;
        end
      end
      ECPH_TO_FWD:
      begin
        // lines stay released until reverse ack returns high
        if (s_arev_n)
        begin
          nxt_hack  = 1'b1;
          nxt_state = ECPH_FWD_IDLE;
        end
      end
      default:
      begin
        nxt_state = ECPH_FWD_IDLE;
      end
    endcase
  end

  // register the handshake step and the pin levels
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff    <= ECPH_FWD_IDLE;
      pdata_ff    <= ECPH_DATA_RST;
      strobe_n_ff <= ECPH_PIN_IDLE;
      hack_ff     <= ECPH_PIN_IDLE;
      dir_n_ff    <= ECPH_PIN_IDLE;
      oe_ff       <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      pdata_ff    <= nxt_pdata;
      strobe_n_ff <= nxt_strobe_n;
      hack_ff     <= nxt_hack;
      dir_n_ff    <= nxt_dir_n;
      oe_ff       <= nxt_oe;
    end
  end

  // ==========================================================================
  // status outputs
  logic err_ff;      // error interrupt condition
  logic nxt_err;
  logic online_ff;   // printer on line
  logic nxt_online;

  // request only counts while the channel runs forward
  always_comb
  begin
    nxt_err    = ecp_en & dir_n_ff & ~s_preq_n;
    nxt_online = s_sel;
  end

  // register the status levels
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      err_ff    <= 1'b0;
      online_ff <= 1'b0;
    end
    else
    begin
      err_ff    <= nxt_err;
      online_ff <= nxt_online;
    end
  end

  // ==========================================================================
  // pin drive
  assign strobe_n    = strobe_n_ff;  // peripheral latches on fall
  assign host_ack    = hack_ff;
  assign dir_n       = dir_n_ff;
  assign select_in_n = ECPH_PIN_IDLE;  // never asserted here
  assign pdata_o     = pdata_ff;
  // peripheral may drive only while host ack low in reverse
  assign pdata_oe    = oe_ff;
  assign dir_rev     = ~dir_n_ff;
  assign err_irq     = err_ff;
  assign online      = online_ff;

endmodule // ecph_port

`default_nettype wire

/* dv/ecph_port_props.sv */
// assertion checker for the ecp host-side handshake port
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// checker on the top-level pins
module ecph_port_props
  import ecph_pkg::*;
#(
  parameter int unsigned DW = ECPH_DATA_W
)
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ecp_en,
  input  wire logic          want_rev,
  input  wire logic          dir_rev,
  input  wire logic          err_irq,
  input  wire logic          online,
  input  wire logic          fwd_valid,
  input  wire logic          fwd_ready,
  input  wire logic [DW-1:0] fwd_data,
  input  wire logic          fwd_cmd,
  input  wire logic          strobe_n,
  input  wire logic          host_ack,
  input  wire logic          dir_n,
  input  wire logic          select_in_n,
  input  wire logic [DW-1:0] pdata_o,
  input  wire logic          pdata_oe,
  input  wire logic          periph_ack,
  input  wire logic          ack_n,
  input  wire logic          ack_rev_n,
  input  wire logic          periph_req_n,
  input  wire logic          select
);
  // one domain, so clock and reset are given once
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // pin level rules
  sel_in_idle_a: assert property (select_in_n)
    else $error("select_in_n not held high");
  online_follow_a: assert property ($stable(select)[*5] |-> online == select)
    else $error("online does not follow select");
  dir_flag_a: assert property (dir_rev == !dir_n)
    else $error("dir_rev disagrees with dir_n");
  dir_change_a: assert property ($fell(dir_n) |-> $past(want_rev))
    else $error("direction turned without host wish");
  drive_oe_a: assert property (pdata_oe |-> dir_n)
    else $error("host drives data while reverse");
  drive_rise_a: assert property ($rose(pdata_oe) |-> dir_n &&
    $past(ack_rev_n) && $past(ack_rev_n, 2))
    else $error("host drive before reverse ack released");

  // ==========================================================================
  // forward interlock
  fwd_mark_a: assert property (fwd_valid && fwd_ready |=> !strobe_n &&
    host_ack == !$past(fwd_cmd) && pdata_o == $past(fwd_data))
    else $error("forward byte not marked on pins");
  fwd_gate_a: assert property (fwd_ready |-> ecp_en && !want_rev &&
    dir_n && strobe_n)
    else $error("forward ready out of idle");
  strobe_lock_a: assert property ($rose(strobe_n) |-> $past(periph_ack, 2))
    else $error("strobe released before busy");

  // ==========================================================================
  // reverse interlock and request
  rev_rise_a: assert property ($rose(host_ack) && !dir_n |->
    !$past(ack_n, 2))
    else $error("host ack rose without byte ack");
  rev_fall_a: assert property ($fell(host_ack) && !dir_n && !$past(dir_n)
    |-> $past(ack_n, 2))
    else $error("host ack fell before byte ack released");
  err_raise_a: assert property ((!periph_req_n && dir_n && ack_rev_n &&
    ecp_en)[*8] |-> err_irq)
    else $error("request did not raise err_irq");
  err_mask_a: assert property ((!dir_n)[*3] |-> !err_irq)
    else $error("err_irq raised in reverse");
endmodule // ecph_port_props

bind ecph_port ecph_port_props #(.DW(DW)) u_props
(
  .clk(clk), .rst(rst), .ecp_en(ecp_en), .want_rev(want_rev),
  .dir_rev(dir_rev), .err_irq(err_irq), .online(online),
  .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_data(fwd_data),
  .fwd_cmd(fwd_cmd), .strobe_n(strobe_n), .host_ack(host_ack),
  .dir_n(dir_n), .select_in_n(select_in_n), .pdata_o(pdata_o),
  .pdata_oe(pdata_oe), .periph_ack(periph_ack), .ack_n(ack_n),
  .ack_rev_n(ack_rev_n), .periph_req_n(periph_req_n), .select(select)
);

`default_nettype wire

/* dv/ecph_periph.sv */
// behavioural ecp peripheral on the far side of the port
`timescale 1ns/1ps
`default_nettype none

module ecph_periph
  import ecph_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic [3:0]             lag,       // answer delay in cycles
  input  wire logic                   hint,      // ask for reverse
  input  wire logic                   on_line,   // printer on line
  input  wire logic                   strobe_n,
  input  wire logic                   host_ack,
  input  wire logic                   dir_n,
  input  wire logic [ECPH_DATA_W-1:0] pdata_o,
  input  wire logic                   pdata_oe,
  output logic [ECPH_DATA_W-1:0]      pdata_i,
  output logic                        periph_ack,
  output logic                        ack_n,
  output logic                        ack_rev_n,
  output logic                        periph_req_n,
  output logic                        select,
  output logic                        got,       // forward byte caught
  output logic [ECPH_WORD_W-1:0]      got_word   // {cmd, data}
);
  logic [ECPH_WORD_W-1:0] send_q[$];             // reverse words to send
  logic [ECPH_DATA_W-1:0] drv      = 8'h00;      // our data drive
  logic                   drv_en   = 1'b0;       // we drive the data
  logic [ECPH_DATA_W-1:0] junk     = 8'hA5;      // released bus pattern

  // ==========================================================================
  // shared data wire: released lines toggle so stale data never matches
  assign pdata_i      = pdata_oe ? pdata_o : (drv_en ? drv : junk);
  assign periph_req_n = !hint;
  assign select       = on_line;
  always @(posedge clk) junk <= ~junk;
  always @(posedge clk) got <= 1'b0;

  task automatic pause();
    repeat (lag) @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // handshake engine, one step per pass
  initial
  begin
    {periph_ack, got, got_word} = 11'h000;
    {ack_n, ack_rev_n} = 2'b11;
    forever
    begin
      @(posedge clk);
      #1;
      if (dir_n && ack_rev_n && !strobe_n)
      begin
        got_word = {!host_ack, pdata_o};
        got = 1'b1;
        pause();
        periph_ack = 1'b1;
        while (!strobe_n) @(posedge clk);
        pause();
        periph_ack = 1'b0;
      end
      else if (!dir_n && ack_rev_n)
      begin
        pause();
        ack_rev_n = 1'b0;
      end
      else if (dir_n && !ack_rev_n)
      begin
        pause();
        periph_ack = 1'b0;
        ack_rev_n = 1'b1;
      end
      else if (!dir_n && !host_ack && send_q.size() > 0)
      begin
        drv = send_q[0][7:0];
        periph_ack = !send_q[0][8];
        drv_en = 1'b1;
        pause();
        ack_n = 1'b0;
        while (!host_ack) @(posedge clk);
        #1;
        drv_en = 1'b0;
        void'(send_q.pop_front());
        ack_n = 1'b1;
      end
    end
  end
endmodule // ecph_periph

`default_nettype wire

/* dv/ecph_port_tb.sv */
// self-checking testbench for the ecp host-side handshake port
`timescale 1ns/1ps
`default_nettype none

module ecph_port_tb;
  import ecph_pkg::*;
  logic clk, rst, ecp_en, want_rev, dir_rev, err_irq, online;
  logic fwd_valid, fwd_ready, fwd_cmd, rev_valid, rev_ready, rev_cmd;
  logic strobe_n, host_ack, dir_n, select_in_n, pdata_oe, periph_ack;
  logic ack_n, ack_rev_n, periph_req_n, select, hint, on_line, got;
  logic go, rnd;                           // consumer ready modes
  logic [7:0] fwd_data, rev_data, pdata_o, pdata_i;
  logic [8:0] got_word, w;
  logic [3:0] lag;
  logic [8:0] fwd_q[$], rev_q[$];          // expected words in order
  int         fail_count, check_count, i, n;
  integer     seed;

  ecph_port u_dut (.clk(clk), .rst(rst), .ecp_en(ecp_en),
    .want_rev(want_rev), .dir_rev(dir_rev), .err_irq(err_irq),
    .online(online), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
    .fwd_data(fwd_data), .fwd_cmd(fwd_cmd), .rev_valid(rev_valid),
    .rev_ready(rev_ready), .rev_data(rev_data), .rev_cmd(rev_cmd),
    .strobe_n(strobe_n), .host_ack(host_ack), .dir_n(dir_n),
    .select_in_n(select_in_n), .pdata_o(pdata_o), .pdata_oe(pdata_oe),
    .pdata_i(pdata_i), .periph_ack(periph_ack), .ack_n(ack_n),
    .ack_rev_n(ack_rev_n), .periph_req_n(periph_req_n), .select(select));
  ecph_periph u_per (.clk(clk), .lag(lag), .hint(hint), .on_line(on_line),
    .strobe_n(strobe_n), .host_ack(host_ack), .dir_n(dir_n),
    .pdata_o(pdata_o), .pdata_oe(pdata_oe), .pdata_i(pdata_i),
    .periph_ack(periph_ack), .ack_n(ack_n), .ack_rev_n(ack_rev_n),
    .periph_req_n(periph_req_n), .select(select), .got(got),
    .got_word(got_word));

  // ==========================================================================
  // clock and helpers
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [8:0] seen,
                     input logic [8:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // offer one forward word, hold it until the port takes it
  task automatic send_fwd(input logic [8:0] v);
    int k;
    k = 0;
    {fwd_valid, fwd_cmd, fwd_data} = {1'b1, v};
    while (fwd_ready !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 300) fail_count++;
    fwd_q.push_back(v);
    @(posedge clk);
    #1;
  endtask

  // ==========================================================================
  // consumer ready: held, random or open; monitor pops the oldest note
  always
  begin
    @(posedge clk);
    #1;
    rev_ready = rnd ? 1'($random(seed)) : go;
  end
  always @(negedge clk)
  begin
    if (got)
      chk("fwd_word", got_word, fwd_q.size() ? fwd_q.pop_front() : 'x);
    if (rev_valid && rev_ready)
      chk("rev_word", {rev_cmd, rev_data},
          rev_q.size() ? rev_q.pop_front() : 'x);
  end

  // ==========================================================================
  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    seed = 32'he9bf;
    {fail_count, check_count} = 0;
    {rst, ecp_en, want_rev, fwd_valid, fwd_cmd, fwd_data} = 13'h1800;
    {lag, hint, on_line, go, rnd, rev_ready} = 9'h000;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    // forward bytes, prompt then slow peripheral
    for (i = 0; i < 8; i++)
    begin
      if (i == 4) lag = 4'h3;
      send_fwd(9'($random(seed)));
    end
    fwd_valid = 1'b0;
    // request hint and on-line in forward
    {hint, on_line} = 2'b11;
    repeat (12) @(posedge clk);
    #1;
    chk("err_irq", {8'h00, err_irq}, 9'h001);
    chk("online", {8'h00, online}, 9'h001);
    chk("dir_n", {8'h00, dir_n}, 9'h001);
    // reverse with a consumer that first refuses everything
    want_rev = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      w = 9'($random(seed));
      u_per.send_q.push_back(w);
      rev_q.push_back(w);
    end
    repeat (60) @(posedge clk);
    #1;
    chk("pending", 9'(u_per.send_q.size()), 9'h004);
    chk("host_ack", {8'h00, host_ack}, 9'h000);
    chk("pdata_oe", {8'h00, pdata_oe}, 9'h000);
    chk("err_irq", {8'h00, err_irq}, 9'h000);
    chk("dir_rev", {8'h00, dir_rev}, 9'h001);
    rnd = 1'b1;
    n = 0;
    while (rev_q.size() > 0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    // back to forward, then two words back to back
    {hint, on_line, want_rev, rnd} = 4'h0;
    n = 0;
    while (pdata_oe !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("dir_n", {8'h00, dir_n}, 9'h001);
    chk("online", {8'h00, online}, 9'h000);
    send_fwd(9'h1FF);
    send_fwd(9'h000);
    fwd_valid = 1'b0;
    repeat (60) @(posedge clk);
    chk("left", 9'(fwd_q.size() + rev_q.size()), 9'h000);
    give_verdict();
  end
endmodule // ecph_port_tb

`default_nettype wire
